//--- rtl/cvf_map.svh
// offsets, field positions, reset values and codes of the cyclic value framer
// How it works
// - selector 127 switches to legacy mode when master sets up as older unit.
// - selector 128 forces legacy-compatibility operation.
// - master sends selector data at setup; device evaluates it then.
// - legacy mode codes status only per older profile 3.0.
// - every analog value travels as one fixed five-byte block.
// - block bytes 0 to 3 carry an IEEE-754 single-precision value.
// - block byte 4 carries the status of that value.
// - sign in bit 7 of byte 0, then exponent, then 23-bit mantissa.
// - value is sign, times one plus mantissa, times two to exponent minus 127.
// - selector 0, 129, 130, 131, or 1 with compact switch off: profile 3.01.
// - selector 1 with compact switch on: profile 3.02 status coding.
// - selector 127: master setup configuration picks 3.0 (legacy), 3.01 or 3.02.
// - at most five slots, at most four measured values per cycle.
// - slots 1 to 4 are read inputs, slot 5 is written display value.
// - block map: general block slot 0, transducer blocks slots 1 and 2.
// - status of each cyclic value shown as a display symbol; only input slots 1 to 4 get one, display slot 5 gets none.
// - inputs come from process temperature, sensor input value and internal reference temperature.
// - each input block takes value chosen by its source select, status at byte 4.
`ifndef CVF_MAP_SVH
`define CVF_MAP_SVH
`define CVF_ADDR_SEL      4'h0
`define CVF_ADDR_CTRL     4'h1
`define CVF_ADDR_SRC      4'h2
`define CVF_ADDR_STAT     4'h3
`define CVF_ADDR_DVAL     4'h4
`define CVF_ADDR_DSTS     4'h5
`define CVF_ADDR_BMAP     4'h6
`define CVF_SEL_RST       8'h7F
`define CVF_SEL_AUTO      8'h7F
`define CVF_SEL_LEGACY    8'h80
`define CVF_SEL_MANUF     8'h01
`define CVF_SEL_PROF4     8'h00
`define CVF_SEL_PROF1     8'h81
`define CVF_SEL_PROF2     8'h82
`define CVF_SEL_PROF3     8'h83
`define CVF_SRC_RST       8'h00
`define CVF_BLK_BYTES     3'h5
`define CVF_AI_SLOTS      3'h4
`define CVF_NO_SLOT       3'h7
`define CVF_DISP_SLOT     3'h4
`define CVF_BMAP_PHYS     4'h0
`define CVF_BMAP_TB1      4'h1
`define CVF_BMAP_TB2      4'h2
`define CVF_CS_BAD        8'h24
`define CVF_CS_UNC        8'h78
`define CVF_CS_GOOD       8'h80
`define CVF_Q_MSB         7
`define CVF_Q_LSB         6
`endif

//--- rtl/cvf_pkg.sv
// types shared by the cyclic value framer
package cvf_pkg;
  typedef enum logic [1:0] {
    CVF_IDLE = 2'b00,
    CVF_LOAD = 2'b01,
    CVF_SEND = 2'b10
  } cvf_state_t;
  typedef enum logic [1:0] {
    CVF_P30  = 2'b00,
    CVF_P301 = 2'b01,
    CVF_P302 = 2'b10
  } cvf_prof_t;
  typedef enum logic [1:0] {
    CVF_SYM_GOOD = 2'b00,
    CVF_SYM_UNC  = 2'b01,
    CVF_SYM_BAD  = 2'b10
  } cvf_sym_t;
  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  status;
  } cvf_meas_t;
  typedef struct packed {
    logic [7:0] byte_d;
    logic       valid;
    logic       last;
  } cvf_tx_t;
endpackage

//--- rtl/cvf_top.sv
// cyclic value framer: input blocks out, display block in, identity mode logic
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cvf_map.svh"
module cvf_top (
  input  wire logic              clk,        // 25 MHz clock
  input  wire logic              arst_n,     // async reset, active low
  input  wire logic [3:0]        reg_addr,   // register index
  input  wire logic [31:0]       reg_wdata,  // register write data
  input  wire logic              reg_wr,     // write strobe
  input  wire logic              reg_rd,     // read strobe
  output logic [31:0]            reg_rdata,  // read data, cycle after strobe
  input  wire cvf_pkg::cvf_meas_t meas_pv,   // process temperature
  input  wire cvf_pkg::cvf_meas_t meas_sv,   // sensor input value
  input  wire cvf_pkg::cvf_meas_t meas_ref,  // internal reference temperature
  input  wire logic              cfg_valid,  // master setup pulse
  input  wire logic [4:0]        cfg_slots,  // enabled slots 5..1
  input  wire logic              cfg_legacy, // master set up as older unit
  input  wire logic              cfg_p302,   // master setup uses 3.02 coding
  input  wire logic              cyc_req,    // start of one cyclic exchange
  input  wire logic              rx_start,   // first display byte marker
  input  wire logic              rx_valid,   // display byte valid
  input  wire logic [7:0]        rx_byte,    // display byte
  output cvf_pkg::cvf_tx_t       tx,         // input block byte stream
  output cvf_pkg::cvf_meas_t     disp,       // last display value received while slot 5 enabled
  output logic [7:0]             disp_sym,   // symbol per input slot, 2 bits
  output logic                   compat,     // legacy mode active
  output logic [1:0]             prof        // status coding profile
);
  typedef struct packed {
    cvf_pkg::cvf_state_t st;
    logic [7:0]          sel;
    logic                compact;
    logic [7:0]          src;
    logic                compat;
    cvf_pkg::cvf_prof_t  prof;
    logic [4:0]          slots;
    logic [2:0]          slot;
    logic [2:0]          bidx;
    logic [39:0]         blk;
    cvf_pkg::cvf_tx_t    tx;
    logic [31:0]         rdata;
    cvf_pkg::cvf_meas_t  disp;
    logic [2:0]          rx_cnt;
    logic [39:0]         rx_sh;
    logic [7:0]          sym;
  } cvf_regs_t;

  logic [1:0] rst_q;
  logic       rst_n;
  cvf_regs_t  r;
  cvf_regs_t  n;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // lowest enabled input slot at or above from, never past four values
  function automatic logic [2:0] next_slot(input logic [4:0] m, input logic [2:0] from);
    logic [2:0] res;
    res = `CVF_NO_SLOT;
    for (int i = 3; i >= 0; i--) begin
      if (m[i] && (3'(i) >= from)) begin
        res = 3'(i);
      end
    end
    return res;
  endfunction

  // status recoding per active profile
  function automatic logic [7:0] code_sts(input cvf_pkg::cvf_prof_t p, input logic [7:0] s);
    logic [7:0] res;
    res = s;
    case (p)
      cvf_pkg::CVF_P30: begin
        // older profile knows no cascade quality: fold it onto plain good
        if (s[`CVF_Q_MSB:`CVF_Q_LSB] == 2'b11) begin
          res = {2'b10, s[5:0]};
        end
      end
      cvf_pkg::CVF_P302: begin
        case (s[`CVF_Q_MSB:`CVF_Q_LSB])
          2'b00:   res = `CVF_CS_BAD;
          2'b01:   res = `CVF_CS_UNC;
          default: res = `CVF_CS_GOOD;
        endcase
      end
      default: res = s;
    endcase
    return res;
  endfunction

  function automatic logic [1:0] sym_of(input logic [7:0] s);
    logic [1:0] res;
    case (s[`CVF_Q_MSB:`CVF_Q_LSB])
      2'b00:   res = cvf_pkg::CVF_SYM_BAD;
      2'b01:   res = cvf_pkg::CVF_SYM_UNC;
      default: res = cvf_pkg::CVF_SYM_GOOD;
    endcase
    return res;
  endfunction

  // source select for one input slot
  function automatic cvf_pkg::cvf_meas_t pick(input logic [1:0] s, input cvf_pkg::cvf_meas_t pv,
                                             input cvf_pkg::cvf_meas_t sv,
                                             input cvf_pkg::cvf_meas_t rf);
    cvf_pkg::cvf_meas_t res;
    case (s)
      2'b01:   res = sv;
      2'b10:   res = rf;
      default: res = pv;
    endcase
    return res;
  endfunction

  cvf_pkg::cvf_meas_t src_m;
  logic [7:0]         coded;
  logic [2:0]         nxt;

  always_comb begin
    n = r;
    n.rdata = 32'h0000_0000;
    n.tx.valid = 1'b0;
    n.tx.last = 1'b0;
    src_m = pick(r.src[2*r.slot[1:0] +: 2], meas_pv, meas_sv, meas_ref);
    coded = code_sts(r.prof, src_m.status);
    nxt = next_slot(r.slots[3:0], 3'(r.slot + 3'h1));

    // software side
    if (reg_wr) begin
      case (reg_addr)
        `CVF_ADDR_SEL:  n.sel = reg_wdata[7:0];
        `CVF_ADDR_CTRL: n.compact = reg_wdata[0];
        `CVF_ADDR_SRC:  n.src = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CVF_ADDR_SEL:  n.rdata = {24'h0, r.sel};
        `CVF_ADDR_CTRL: n.rdata = {31'h0, r.compact};
        `CVF_ADDR_SRC:  n.rdata = {24'h0, r.src};
        `CVF_ADDR_STAT: n.rdata = {16'h0, r.sym, r.slots, r.compat, r.prof};
        `CVF_ADDR_DVAL: n.rdata = r.disp.value;
        `CVF_ADDR_DSTS: n.rdata = {24'h0, r.disp.status};
        `CVF_ADDR_BMAP: n.rdata = {20'h0, `CVF_BMAP_TB2, `CVF_BMAP_TB1, `CVF_BMAP_PHYS};
        default:        n.rdata = 32'h0000_0000;
      endcase
    end

    // identity evaluation when the master sets up cyclic exchange
    if (cfg_valid) begin
      n.slots = cfg_slots;
      n.compat = 1'b0;
      n.prof = cvf_pkg::CVF_P301;
      case (r.sel)
        `CVF_SEL_LEGACY: n.compat = 1'b1;
        `CVF_SEL_AUTO: begin
          n.compat = cfg_legacy;
          n.prof = cfg_p302 ? cvf_pkg::CVF_P302 : cvf_pkg::CVF_P301;
        end
        `CVF_SEL_MANUF: begin
          n.prof = r.compact ? cvf_pkg::CVF_P302 : cvf_pkg::CVF_P301;
        end
        `CVF_SEL_PROF4, `CVF_SEL_PROF1, `CVF_SEL_PROF2, `CVF_SEL_PROF3: begin
          n.prof = cvf_pkg::CVF_P301;
        end
        default: n.prof = cvf_pkg::CVF_P301;
      endcase
      if (n.compat) begin
        n.prof = cvf_pkg::CVF_P30;
      end
    end

    // input block framing
    case (r.st)
      cvf_pkg::CVF_IDLE: begin
        if (cyc_req && !cfg_valid) begin
          n.slot = next_slot(r.slots[3:0], 3'h0);
          if (n.slot != `CVF_NO_SLOT) begin
            n.st = cvf_pkg::CVF_LOAD;
          end
        end
      end
      cvf_pkg::CVF_LOAD: begin
        // value passes untouched: it is already sign, exponent, mantissa
        n.blk = {src_m.value, coded};
        n.sym[2*r.slot[1:0] +: 2] = sym_of(coded);
        n.bidx = 3'h0;
        n.st = cvf_pkg::CVF_SEND;
      end
      cvf_pkg::CVF_SEND: begin
        n.tx.byte_d = r.blk[39:32];
        n.tx.valid = 1'b1;
        n.blk = {r.blk[31:0], 8'h00};
        n.bidx = 3'(r.bidx + 3'h1);
        if (r.bidx == 3'(`CVF_BLK_BYTES - 3'h1)) begin
          n.slot = nxt;
          if (nxt == `CVF_NO_SLOT) begin
            n.tx.last = 1'b1;
            n.st = cvf_pkg::CVF_IDLE;
          end else begin
            n.st = cvf_pkg::CVF_LOAD;
          end
        end
      end
      default: n.st = cvf_pkg::CVF_IDLE;
    endcase

    // display block written by the master
    if (rx_valid) begin
      if (rx_start) begin
        n.rx_cnt = 3'h1;
        n.rx_sh = {32'h0, rx_byte};
      end else if (r.rx_cnt != 3'h0) begin
        n.rx_cnt = 3'(r.rx_cnt + 3'h1);
        n.rx_sh = {r.rx_sh[31:0], rx_byte};
      end
      // stray bytes without a start marker are dropped
      if ((n.rx_cnt == `CVF_BLK_BYTES) && r.slots[`CVF_DISP_SLOT]) begin
        n.disp = {n.rx_sh[39:8], n.rx_sh[7:0]};
        n.rx_cnt = 3'h0;
      end else if (n.rx_cnt == `CVF_BLK_BYTES) begin
        n.rx_cnt = 3'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: cvf_pkg::CVF_IDLE, sel: `CVF_SEL_RST, compact: 1'b0, src: `CVF_SRC_RST,
             compat: 1'b0, prof: cvf_pkg::CVF_P301, slots: 5'h00, slot: 3'h0, bidx: 3'h0,
             blk: 40'h00_0000_0000, tx: '0, rdata: 32'h0000_0000, disp: '0, rx_cnt: 3'h0,
             rx_sh: 40'h00_0000_0000, sym: 8'h00};
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign tx        = r.tx;
  assign disp      = r.disp;
  assign disp_sym  = r.sym;
  assign compat    = r.compat;
  assign prof      = r.prof;
endmodule
`default_nettype wire

//--- bench/cvf_top_sva.sv
// concurrent checks on the ports of the cyclic value framer
`timescale 1ns/1ps
`default_nettype none
module cvf_top_chk (
  input wire logic               clk,       // clock
  input wire logic               arst_n,    // async reset, active low
  input wire logic               reg_rd,    // read strobe
  input wire logic [3:0]         reg_addr,  // register index
  input wire logic [31:0]        reg_rdata, // read data
  input wire logic               cfg_valid, // setup pulse
  input wire logic               cyc_req,   // frame request
  input wire logic               rx_valid,  // display byte valid
  input wire cvf_pkg::cvf_tx_t   tx,        // input block stream
  input wire cvf_pkg::cvf_meas_t disp,      // display value
  input wire logic               compat,    // legacy mode
  input wire logic [1:0]         prof       // coding profile
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_block;
    tx.valid [*5] ##1 !tx.valid;
  endsequence
  property p_block;
    $rose(tx.valid) |-> s_block;
  endproperty
  // first byte of a frame, not of a later slot: launched two edges after the request edge,
  // so it is first sampled three ticks after cyc_req was
  property p_start;
    $rose(tx.valid) && !$past(tx.valid, 2) |-> $past(cyc_req, 3);
  endproperty
  property p_gap;
    tx.last |-> tx.valid ##1 !tx.valid;
  endproperty
  property p_compat;
    compat |-> prof == 2'b00;
  endproperty
  property p_setup;
    !$past(cfg_valid) && !$past(cfg_valid, 2) |-> $stable(compat) && $stable(prof);
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  property p_bmap;
    reg_rd && reg_addr == 4'h6 |=> reg_rdata == 32'h0000_0210;
  endproperty
  property p_disp;
    !$stable(disp) |-> $past(rx_valid);
  endproperty
  a_block: assert property (p_block) else $error("block not five bytes");
  a_start: assert property (p_start) else $error("frame start late");
  a_gap: assert property (p_gap) else $error("byte after last");
  a_compat: assert property (p_compat) else $error("legacy not 3.0");
  a_setup: assert property (p_setup) else $error("mode moved off setup");
  a_rd_idle: assert property (p_rd_idle) else $error("read data stray");
  a_bmap: assert property (p_bmap) else $error("block map wrong");
  a_disp: assert property (p_disp) else $error("display moved alone");
endmodule
`default_nettype wire

//--- bench/cvf_master_model.sv
// cyclic master model: display block sender and input byte collector
`timescale 1ns/1ps
`default_nettype none
module cvf_master_model (
  input wire logic             clk,      // clock
  input wire cvf_pkg::cvf_tx_t tx,       // input block stream
  output logic                 rx_start, // first display byte
  output logic                 rx_valid, // display byte valid
  output logic [7:0]           rx_byte   // display byte
);
  logic [7:0] txq[$];
  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  always @(posedge clk) begin
    if (tx.valid) begin
      txq.push_back(tx.byte_d);
    end
  end
  task automatic send_disp(input logic [39:0] blk);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rx_start <= (i == 0);
      rx_valid <= 1'b1;
      rx_byte  <= blk[39 - 8 * i -: 8];
    end
    @(posedge clk);
    rx_start <= 1'b0;
    rx_valid <= 1'b0;
    // released line must not keep showing the last byte
    rx_byte  <= ~rx_byte;
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the cyclic value framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] sel;
    logic       cmp, leg, p302, ec;
    logic [1:0] ep;
    logic [7:0] es;
  } cvf_row_t;
  logic               clk, arst_n, reg_wr, reg_rd, cfg_valid, cfg_legacy, cfg_p302;
  logic               cyc_req, rx_start, rx_valid, compat;
  logic [3:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata;
  logic [4:0]         cfg_slots;
  logic [7:0]         rx_byte, disp_sym;
  logic [1:0]         prof;
  cvf_pkg::cvf_meas_t meas_pv, meas_sv, meas_ref, disp;
  cvf_pkg::cvf_tx_t   tx;
  int                 err_total, check_count;
  // process value status is 8'hC0, so profiles 3.0 and 3.02 recode it visibly to 8'h80, while 3.01 passes it unchanged
  cvf_row_t rows [11] = '{'{8'h7F, 0, 1, 0, 1, 2'h0, 8'h80}, '{8'h7F, 0, 0, 1, 0, 2'h2, 8'h80},
    '{8'h7F, 0, 0, 0, 0, 2'h1, 8'hC0}, '{8'h80, 0, 0, 0, 1, 2'h0, 8'h80},
    '{8'h00, 0, 0, 0, 0, 2'h1, 8'hC0}, '{8'h81, 0, 0, 0, 0, 2'h1, 8'hC0},
    '{8'h82, 0, 0, 0, 0, 2'h1, 8'hC0}, '{8'h83, 0, 0, 0, 0, 2'h1, 8'hC0},
    '{8'h01, 0, 0, 0, 0, 2'h1, 8'hC0}, '{8'h01, 1, 0, 0, 0, 2'h2, 8'h80},
    '{8'h05, 0, 1, 0, 0, 2'h1, 8'hC0}};
  cvf_top u_cvf_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_pv(meas_pv),
    .meas_sv(meas_sv), .meas_ref(meas_ref), .cfg_valid(cfg_valid), .cfg_slots(cfg_slots),
    .cfg_legacy(cfg_legacy), .cfg_p302(cfg_p302), .cyc_req(cyc_req), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx(tx), .disp(disp), .disp_sym(disp_sym),
    .compat(compat), .prof(prof));
  cvf_master_model u_mst (.clk(clk), .tx(tx), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_byte(rx_byte));
  task automatic chk(input logic [119:0] got, input logic [119:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic setup(input logic [4:0] s, input logic l, input logic p);
    @(posedge clk);
    cfg_valid  <= 1'b1;
    cfg_slots  <= s;
    cfg_legacy <= l;
    cfg_p302   <= p;
    @(posedge clk);
    cfg_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic frame_chk(input logic [119:0] e, input int n);
    logic [119:0] got;
    got = '0;
    u_mst.txq.delete();
    @(posedge clk);
    cyc_req <= 1'b1;
    @(posedge clk);
    cyc_req <= 1'b0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (tx.last === 1'b1) break;
    end
    @(posedge clk);
    #1 chk(u_mst.txq.size(), n);
    for (int i = 0; i < n; i++) got = {got[111:0], u_mst.txq[i]};
    chk(got, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, cfg_valid, cfg_legacy, cfg_p302, cyc_req} = '0;
    {reg_addr, reg_wdata, cfg_slots} = '0;
    meas_pv  = {32'h40F0_0000, 8'hC0};
    meas_sv  = {32'hC120_0000, 8'h4C};
    meas_ref = {32'h41C8_0000, 8'h80};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 32'h7F);
    rd(4'h6, 32'h210);
    rd(4'h7, 32'h0);
    foreach (rows[i]) begin
      wr(4'h0, {24'h0, rows[i].sel});
      wr(4'h1, {31'h0, rows[i].cmp});
      setup(5'b10001, rows[i].leg, rows[i].p302);
      chk({compat, prof}, {rows[i].ec, rows[i].ep});
      frame_chk({32'h40F0_0000, rows[i].es}, 5);
    end
    wr(4'h0, 32'h0);
    wr(4'h2, 32'h24);
    setup(5'b01011, 1'b0, 1'b0);
    frame_chk({meas_pv, meas_sv, meas_pv}, 15);
    setup(5'b00111, 1'b0, 1'b0);
    frame_chk({meas_pv, meas_sv, meas_ref}, 15);
    // symbols: slot 2 carries an uncertain status, the other three good
    chk(disp_sym, 8'h04);
    rd(4'h3, 32'h0000_0439);
    // only the display slot enabled: a request must give no bytes
    setup(5'b10000, 1'b0, 1'b0);
    frame_chk(120'h0, 0);
    setup(5'b10001, 1'b0, 1'b0);
    u_mst.send_disp({32'h3FC0_0000, 8'h80});
    repeat (2) @(posedge clk);
    #1 chk(disp, {32'h3FC0_0000, 8'h80});
    rd(4'h4, 32'h3FC0_0000);
    rd(4'h5, 32'h0000_0080);
    setup(5'b00001, 1'b0, 1'b0);
    u_mst.send_disp({32'hBF80_0000, 8'h24});
    repeat (2) @(posedge clk);
    #1 chk(disp, {32'h3FC0_0000, 8'h80});
    close_out();
  end
endmodule
bind cvf_top cvf_top_chk u_chk (.clk(clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .cfg_valid(cfg_valid), .cyc_req(cyc_req),
  .rx_valid(rx_valid), .tx(tx), .disp(disp), .compat(compat), .prof(prof));
`default_nettype wire
